// ==== shared/usm_pkg.sv ====
// Constants shared by the special line mode serial block.
// Assumes a single 20 MHz clock and a plain register port.
package usm_pkg;
   // Register offsets
   localparam logic [7:0] CONTROL_REG_OFS = 8'h00;
   localparam logic [7:0] MODE_REG_OFS = 8'h04;
   localparam logic [7:0] CHANNEL_STATUS_REG_OFS = 8'h14;
   localparam logic [7:0] RECEIVE_HOLDING_REG_OFS = 8'h18;
   localparam logic [7:0] TRANSMIT_HOLDING_REG_OFS = 8'h1c;
   localparam logic [7:0] BAUD_REG_OFS = 8'h20;
   localparam logic [7:0] TIMEGUARD_REG_OFS = 8'h28;
   localparam logic [7:0] CARD_RATIO_REG_OFS = 8'h40;
   localparam logic [7:0] ERROR_COUNT_REG_OFS = 8'h44;
   localparam logic [7:0] DEMOD_FILTER_REG_OFS = 8'h4c;
   // Control register bit positions
   localparam int CTL_CLR_PARITY_BIT = 8;
   localparam int CTL_RX_ENABLE_BIT = 4;
   localparam int CTL_RX_DISABLE_BIT = 5;
   localparam int CTL_TX_ENABLE_BIT = 6;
   localparam int CTL_TX_DISABLE_BIT = 7;
   localparam int CTL_CLEAR_REPEAT_FLAG_BIT = 13;
   localparam int CTL_CLEAR_INHIBIT_FLAG_BIT = 14;
   // Mode register field positions
   localparam int MODE_LINE_LSB = 0;
   localparam int MODE_PARITY_EN_BIT = 9;
   localparam int MODE_CHANNEL_LSB = 14;
   localparam int MODE_SUPPRESS_ERROR_SIGNAL_BIT = 20;
   localparam int MODE_LIMIT_SUCCESSIVE_ERRORS_BIT = 21;
   localparam int MODE_REPEAT_LIMIT_LSB = 24;
   // Channel status register bit positions
   localparam int STS_RX_AVAIL_BIT = 0;
   localparam int STS_TX_READY_BIT = 1;
   localparam int STS_PARITY_ERROR_BIT = 7;
   localparam int STS_TX_IDLE_BIT = 9;
   localparam int STS_REPEAT_FLAG_BIT = 10;
   localparam int STS_INHIBIT_FLAG_BIT = 13;
   // Line mode codes
   localparam logic [3:0] LINE_NORMAL = 4'h0;
   localparam logic [3:0] LINE_DRIVER = 4'h1;
   localparam logic [3:0] LINE_CARD_CHAR = 4'h4;
   localparam logic [3:0] LINE_CARD_BLOCK = 4'h5;
   localparam logic [3:0] LINE_INFRARED = 4'h8;
   // Channel mode codes
   localparam logic [1:0] CHAN_NORMAL = 2'h0;
   localparam logic [1:0] CHAN_ECHO = 2'h1;
   // Reset values
   localparam logic [10:0] CARD_RATIO_RESET = 11'h174;
   localparam logic [15:0] BAUD_RESET = 16'h0000;
   // Bit timing in divider ticks, and the error count limit
   localparam logic [3:0] TICK_SAMPLE = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [3:0] PULSE_TICKS = 4'h3;
   localparam logic [7:0] ERROR_COUNT_MAX = 8'hff;
   localparam logic [4:0] DEMOD_LOW_TICKS = 5'h10;
endpackage

// ==== verilog/usm_baud_div.sv ====
// Baud divider: one-cycle tick at sixteen times the bit rate.
// Assumes divisor zero stops the ticks.
`timescale 1ns/1ps
module usm_baud_div #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Divisor and tick
   input wire logic [WIDTH-1:0] divisor,
   output logic tick
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge clock) begin
      if (srst || divisor == '0) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count >= divisor - 1'b1) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// ==== verilog/usm_ir_demod.sv ====
// Infrared demodulator filter with an 8-bit down counter.
// Assumes rxIn is already synchronised to clock.
`timescale 1ns/1ps
module usm_ir_demod
   import usm_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Settings and bit tick
   input wire logic [7:0] filterValue,
   input wire logic tick,
   // Line
   input wire logic rxIn,
   output logic rxOut
);
   logic rxPrev;
   logic running;
   logic [7:0] count;
   logic [4:0] lowTicks;

   always_ff @(posedge clock) begin
      if (srst) begin
         rxPrev <= 1'b1;
      end else begin
         rxPrev <= rxIn;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         running <= 1'b0;
         count <= 8'h00;
      end else if (!running && rxPrev && !rxIn) begin
         running <= 1'b1;
         count <= filterValue;
      end else if (running && !rxPrev && rxIn) begin
         running <= 1'b0;
         count <= filterValue;
      end else if (running && count == 8'h00) begin
         running <= 1'b0;
         count <= filterValue;
      end else if (running) begin
         count <= count - 8'h01;
      end
   end

   // Receiver input held low for one bit time
   always_ff @(posedge clock) begin
      if (srst) begin
         lowTicks <= 5'h00;
         rxOut <= 1'b1;
      end else if (running && count == 8'h00 && !(!rxPrev && rxIn)) begin
         lowTicks <= DEMOD_LOW_TICKS;
         rxOut <= 1'b0;
      end else if (lowTicks != 5'h00) begin
         if (tick) begin
            lowTicks <= lowTicks - 5'h01;
         end
         rxOut <= 1'b0;
      end else begin
         rxOut <= 1'b1;
      end
   end
endmodule

// ==== verilog/usm_core.sv ====
// Serial transceiver with smart-card, infrared, line-driver and echo modes.
// Assumes a 20 MHz clock, a plain register port and a half-duplex data pin.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module usm_core
   import usm_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // Line pins
   input wire logic rxPin,
   output logic txPinOut,
   output logic txPinOe,
   output logic rtsPin
);
   typedef enum logic [2:0] {
      USM_RX_IDLE = 3'b000, USM_RX_START = 3'b001, USM_RX_DATA = 3'b010,
      USM_RX_PARITY = 3'b011, USM_RX_GUARD = 3'b100, USM_RX_EXTRA = 3'b101
   } usm_rx_state_type;
   typedef enum logic [2:0] {
      USM_TX_IDLE = 3'b000, USM_TX_START = 3'b001, USM_TX_DATA = 3'b010,
      USM_TX_PARITY = 3'b011, USM_TX_GUARD = 3'b100, USM_TX_EXTRA = 3'b101,
      USM_TX_TGUARD = 3'b110
   } usm_tx_state_type;

   // Saturating increment of the error count
   function automatic logic [7:0] sat_inc(input logic [7:0] value);
      sat_inc = (value == ERROR_COUNT_MAX) ? value : value + 8'h01;
   endfunction

   // Registers
   logic [31:0] mode_register;
   logic [15:0] baudDivisor;
   logic [7:0] timeguard;
   logic [10:0] card_clock_ratio_field;
   logic [7:0] demod_filter_register;
   logic [7:0] error_count_field;
   logic [7:0] receive_holding_register;
   logic [7:0] txHolding;
   logic txHoldFull;
   logic receive_char_available;
   logic parity_error_flag;
   logic repeatFlag;
   logic inhibitFlag;
   logic rxEnabled;
   logic txEnabled;

   // Mode decode
   logic [3:0] lineMode;
   logic [1:0] channelMode;
   logic [2:0] repeatLimit;
   logic cardChar;
   logic cardMode;
   logic parityOn;
   logic infrared;
   assign lineMode = mode_register[MODE_LINE_LSB +: 4];
   assign channelMode = mode_register[MODE_CHANNEL_LSB +: 2];
   assign repeatLimit = mode_register[MODE_REPEAT_LIMIT_LSB +: 3];
   assign cardChar = (lineMode == LINE_CARD_CHAR);
   assign cardMode = cardChar || (lineMode == LINE_CARD_BLOCK);
   assign parityOn = cardMode || mode_register[MODE_PARITY_EN_BIT];
   assign infrared = (lineMode == LINE_INFRARED);

   // Register port strobes
   logic wrCtl;
   logic rdHolding;
   logic rdErrors;
   assign wrCtl = regWrite && regAddr == CONTROL_REG_OFS;
   assign rdHolding = regRead && regAddr == RECEIVE_HOLDING_REG_OFS;
   assign rdErrors = regRead && regAddr == ERROR_COUNT_REG_OFS;

   // Receive pin synchroniser
   logic rxMeta;
   logic rxSync;
   always_ff @(posedge clock) begin
      if (srst) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
      end else begin
         rxMeta <= rxPin;
         rxSync <= rxMeta;
      end
   end

   logic tick;
   usm_baud_div #(.WIDTH(16)) baudDiv (
      .clock(clock),
      .srst(srst),
      .divisor(baudDivisor),
      .tick(tick)
   );

   logic demodOut;
   usm_ir_demod irDemod (
      .clock(clock),
      .srst(srst),
      .filterValue(demod_filter_register),
      .tick(tick),
      .rxIn(rxSync),
      .rxOut(demodOut)
   );

   logic rxLine;
   assign rxLine = infrared ? demodOut : rxSync;

   // Configuration registers
   always_ff @(posedge clock) begin
      if (srst) begin
         mode_register <= 32'h00000000;
         baudDivisor <= BAUD_RESET;
         timeguard <= 8'h00;
         card_clock_ratio_field <= CARD_RATIO_RESET;
         demod_filter_register <= 8'h00;
      end else if (regWrite) begin
         case (regAddr)
            MODE_REG_OFS: mode_register <= regWrData;
            BAUD_REG_OFS: baudDivisor <= regWrData[15:0];
            TIMEGUARD_REG_OFS: timeguard <= regWrData[7:0];
            CARD_RATIO_REG_OFS: card_clock_ratio_field <= regWrData[10:0];
            DEMOD_FILTER_REG_OFS: demod_filter_register <= regWrData[7:0];
            default: ;
         endcase
      end
   end

   // Enables
   always_ff @(posedge clock) begin
      if (srst) begin
         rxEnabled <= 1'b0;
         txEnabled <= 1'b0;
      end else if (wrCtl) begin
         if (regWrData[CTL_RX_DISABLE_BIT]) begin
            rxEnabled <= 1'b0;
         end else if (regWrData[CTL_RX_ENABLE_BIT]) begin
            rxEnabled <= 1'b1;
         end
         if (regWrData[CTL_TX_DISABLE_BIT]) begin
            txEnabled <= 1'b0;
         end else if (regWrData[CTL_TX_ENABLE_BIT]) begin
            txEnabled <= 1'b1;
         end
      end
   end

   // Receiver
   usm_rx_state_type rxState;
   logic [3:0] rxTick;
   logic [2:0] rxBit;
   logic [7:0] rxShift;
   logic [2:0] nackCount;
   logic rxNack;
   logic rxDone;
   logic rxBad;
   logic rxLimit;
   logic rxAccept;
   logic rxSignal;
   logic rxSample;
   logic rxEdge;
   assign rxSample = tick && rxTick == TICK_SAMPLE;
   assign rxEdge = tick && rxTick == TICK_LAST;
   assign rxDone = rxState == USM_RX_PARITY && rxSample;
   assign rxBad = rxDone && (rxLine != ^rxShift);
   assign rxLimit = cardChar && mode_register[MODE_LIMIT_SUCCESSIVE_ERRORS_BIT] && nackCount == repeatLimit;
   assign rxSignal = rxBad && cardChar && !mode_register[MODE_SUPPRESS_ERROR_SIGNAL_BIT] && !rxLimit;
   assign rxAccept = (rxDone && !rxSignal) || (!parityOn && rxState == USM_RX_GUARD && rxSample);

   always_ff @(posedge clock) begin
      if (srst || !rxEnabled) begin
         rxState <= USM_RX_IDLE;
         rxTick <= 4'h0;
         rxBit <= 3'h0;
         rxShift <= 8'h00;
      end else begin
         rxTick <= (rxState == USM_RX_IDLE) ? 4'h0 : rxTick + {3'h0, tick};
         case (rxState)
            USM_RX_IDLE: begin
               if (!rxLine) begin
                  rxState <= USM_RX_START;
               end
            end
            USM_RX_START: begin
               if (rxSample && rxLine) begin
                  rxState <= USM_RX_IDLE;
               end else if (rxEdge) begin
                  rxState <= USM_RX_DATA;
                  rxBit <= 3'h0;
               end
            end
            USM_RX_DATA: begin
               if (rxSample) begin
                  rxShift <= {rxLine, rxShift[7:1]};
               end
               if (rxEdge) begin
                  rxBit <= rxBit + 3'h1;
                  if (rxBit == 3'h7) begin
                     rxState <= parityOn ? USM_RX_PARITY : USM_RX_GUARD;
                  end
               end
            end
            USM_RX_PARITY: begin
               if (rxEdge) begin
                  rxState <= USM_RX_GUARD;
               end
            end
            USM_RX_GUARD: begin
               if (rxEdge) begin
                  rxState <= rxNack ? USM_RX_EXTRA : USM_RX_IDLE;
               end
            end
            USM_RX_EXTRA: begin
               if (rxEdge) begin
                  rxState <= USM_RX_IDLE;
               end
            end
            default: rxState <= USM_RX_IDLE;
         endcase
      end
   end

   // Error signal request and successive error count
   always_ff @(posedge clock) begin
      if (srst || !rxEnabled) begin
         rxNack <= 1'b0;
         nackCount <= 3'h0;
      end else if (rxDone) begin
         rxNack <= rxSignal;
         nackCount <= rxSignal ? nackCount + 3'h1 : 3'h0;
      end else if (rxState == USM_RX_IDLE) begin
         rxNack <= 1'b0;
      end
   end

   // Receive holding register and flags
   always_ff @(posedge clock) begin
      if (srst) begin
         receive_holding_register <= 8'h00;
         receive_char_available <= 1'b0;
      end else begin
         if (rxAccept) begin
            receive_holding_register <= rxShift;
         end
         if (rxAccept && !(rxBad && cardChar && mode_register[MODE_SUPPRESS_ERROR_SIGNAL_BIT])) begin
            receive_char_available <= 1'b1;
         end else if (rdHolding) begin
            receive_char_available <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         error_count_field <= 8'h00;
      end else if (rxBad) begin
         error_count_field <= rdErrors ? 8'h01 : sat_inc(error_count_field);
      end else if (rdErrors) begin
         error_count_field <= 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         parity_error_flag <= 1'b0;
      end else if (rxBad && !cardChar) begin
         parity_error_flag <= 1'b1;
      end else if (wrCtl && regWrData[CTL_CLR_PARITY_BIT]) begin
         parity_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         inhibitFlag <= 1'b0;
      end else if (rxBad && cardChar && mode_register[MODE_SUPPRESS_ERROR_SIGNAL_BIT]) begin
         inhibitFlag <= 1'b1;
      end else if (wrCtl && regWrData[CTL_CLEAR_INHIBIT_FLAG_BIT]) begin
         inhibitFlag <= 1'b0;
      end
   end

   // Transmitter
   usm_tx_state_type txState;
   logic [3:0] txTick;
   logic [2:0] txBit;
   logic [7:0] txShift;
   logic [7:0] txData;
   logic [2:0] iteration;
   logic [7:0] tgCount;
   logic txNackSeen;
   logic txLevel;
   logic txDrive;
   logic txSample;
   logic txEdge;
   logic txRepeatHit;
   logic transmitter_idle_flag;
   assign txSample = tick && txTick == TICK_SAMPLE;
   assign txEdge = tick && txTick == TICK_LAST;
   assign transmitter_idle_flag = txState == USM_TX_IDLE && !txHoldFull;
   assign txRepeatHit = txState == USM_TX_GUARD && txEdge && txBit == 3'h1 && cardChar && txNackSeen
      && repeatLimit != 3'h0 && iteration + 3'h1 == repeatLimit;

   always_ff @(posedge clock) begin
      if (srst) begin
         txHolding <= 8'h00;
         txHoldFull <= 1'b0;
      end else if (regWrite && regAddr == TRANSMIT_HOLDING_REG_OFS && !txHoldFull) begin
         txHolding <= regWrData[7:0];
         txHoldFull <= 1'b1;
      end else if (txState == USM_TX_IDLE && txEnabled && txHoldFull) begin
         txHoldFull <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || !txEnabled) begin
         txState <= USM_TX_IDLE;
         txTick <= 4'h0;
         txBit <= 3'h0;
         txShift <= 8'h00;
         txData <= 8'h00;
         iteration <= 3'h0;
         tgCount <= 8'h00;
         txNackSeen <= 1'b0;
         txLevel <= 1'b1;
         txDrive <= 1'b0;
      end else begin
         txTick <= (txState == USM_TX_IDLE) ? 4'h0 : txTick + {3'h0, tick};
         case (txState)
            USM_TX_IDLE: begin
               txLevel <= 1'b1;
               txDrive <= 1'b0;
               if (txHoldFull) begin
                  txData <= txHolding;
                  txShift <= txHolding;
                  txState <= USM_TX_START;
                  txLevel <= 1'b0;
                  txDrive <= 1'b1;
               end
            end
            USM_TX_START: begin
               if (txEdge) begin
                  txState <= USM_TX_DATA;
                  txBit <= 3'h0;
                  txLevel <= txShift[0];
               end
            end
            USM_TX_DATA: begin
               if (txEdge) begin
                  txBit <= txBit + 3'h1;
                  txShift <= {1'b0, txShift[7:1]};
                  if (txBit == 3'h7) begin
                     txState <= parityOn ? USM_TX_PARITY : USM_TX_GUARD;
                     txLevel <= parityOn ? ^txData : 1'b1;
                     txDrive <= parityOn || !cardMode;
                     txBit <= 3'h0;
                  end else begin
                     txLevel <= txShift[1];
                  end
               end
            end
            USM_TX_PARITY: begin
               if (txEdge) begin
                  txState <= USM_TX_GUARD;
                  txLevel <= 1'b1;
                  txDrive <= !cardMode;
                  txNackSeen <= 1'b0;
               end
            end
            USM_TX_GUARD: begin
               if (txSample && txBit == 3'h0 && !rxSync) begin
                  txNackSeen <= 1'b1;
               end
               if (txEdge) begin
                  txBit <= txBit + 3'h1;
                  if (!cardChar || txBit == 3'h1) begin
                     txBit <= 3'h0;
                     if (cardChar && txNackSeen && iteration < repeatLimit) begin
                        iteration <= iteration + 3'h1;
                        txState <= USM_TX_EXTRA;
                     end else begin
                        iteration <= 3'h0;
                        tgCount <= timeguard;
                        txState <= (timeguard != 8'h00) ? USM_TX_TGUARD : USM_TX_IDLE;
                     end
                  end
               end
            end
            USM_TX_EXTRA: begin
               if (txEdge) begin
                  txShift <= txData;
                  txState <= USM_TX_START;
                  txLevel <= 1'b0;
                  txDrive <= 1'b1;
               end
            end
            USM_TX_TGUARD: begin
               if (txEdge) begin
                  tgCount <= tgCount - 8'h01;
                  if (tgCount == 8'h01) begin
                     txState <= USM_TX_IDLE;
                  end
               end
            end
            default: txState <= USM_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         repeatFlag <= 1'b0;
      end else if (txRepeatHit || (rxDone && rxBad && rxLimit)) begin
         repeatFlag <= 1'b1;
      end else if (wrCtl && regWrData[CTL_CLEAR_REPEAT_FLAG_BIT]) begin
         repeatFlag <= 1'b0;
      end
   end

   // Pin drive
   logic bitHigh;
   assign bitHigh = txTick < PULSE_TICKS;
   always_ff @(posedge clock) begin
      if (srst) begin
         txPinOut <= 1'b1;
         txPinOe <= 1'b1;
      end else if (channelMode == CHAN_ECHO) begin
         txPinOut <= rxSync;
         txPinOe <= 1'b1;
      end else if (rxNack && rxState == USM_RX_GUARD) begin
         txPinOut <= 1'b0;
         txPinOe <= 1'b1;
      end else if (infrared) begin
         txPinOut <= txState != USM_TX_IDLE && !txLevel && bitHigh;
         txPinOe <= 1'b1;
      end else begin
         txPinOut <= txLevel;
         txPinOe <= cardMode ? txDrive : 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rtsPin <= 1'b0;
      end else begin
         rtsPin <= (lineMode == LINE_DRIVER) && !transmitter_idle_flag;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (srst) begin
         regRdData <= 32'h00000000;
      end else if (regRead) begin
         regRdData <= 32'h00000000;
         case (regAddr)
            MODE_REG_OFS: regRdData <= mode_register;
            CHANNEL_STATUS_REG_OFS: begin
               regRdData[STS_RX_AVAIL_BIT] <= receive_char_available;
               regRdData[STS_TX_READY_BIT] <= !txHoldFull;
               regRdData[STS_PARITY_ERROR_BIT] <= parity_error_flag;
               regRdData[STS_TX_IDLE_BIT] <= transmitter_idle_flag;
               regRdData[STS_REPEAT_FLAG_BIT] <= repeatFlag;
               regRdData[STS_INHIBIT_FLAG_BIT] <= inhibitFlag;
            end
            RECEIVE_HOLDING_REG_OFS: regRdData[7:0] <= receive_holding_register;
            BAUD_REG_OFS: regRdData[15:0] <= baudDivisor;
            TIMEGUARD_REG_OFS: regRdData[7:0] <= timeguard;
            CARD_RATIO_REG_OFS: regRdData[10:0] <= card_clock_ratio_field;
            ERROR_COUNT_REG_OFS: regRdData[7:0] <= error_count_field;
            DEMOD_FILTER_REG_OFS: regRdData[7:0] <= demod_filter_register;
            default: ;
         endcase
      end
   end
endmodule

// ==== dv/usm_core_chk.sv ====
// Port checker for the special line mode core.
// Assumes baud divisor 2 in infrared mode.
`timescale 1ns/1ps
module usm_core_chk
   import usm_pkg::*;
(
   // Watched ports
   input wire logic clock, srst, regWrite, regRead, rxPin, txPinOut, txPinOe, rtsPin,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData, regRdData
);
   logic [31:0] mode;
   wire echo = mode[15:14] == CHAN_ECHO;
   wire drv = mode[3:0] == LINE_DRIVER;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   always_ff @(posedge clock)
      if (srst) mode <= 32'h0;
      else if (regWrite && regAddr == MODE_REG_OFS) mode <= regWrData;
   a_reset_idle: assert property ($fell(srst) |-> txPinOut && txPinOe && !rtsPin && regRdData == 32'h0)
      else $error("pins not idle");
   a_count_width: assert property (regRead && regAddr == ERROR_COUNT_REG_OFS |=> regRdData[31:8] == 24'h0)
      else $error("count too wide");
   a_read_hold: assert property (!regRead |=> $stable(regRdData))
      else $error("read data moved");
   a_echo_copy: assert property (echo && $past(echo, 4) |-> txPinOut == $past(rxPin, 3))
      else $error("echo differs");
   a_rts_follow: assert property (drv && !echo && !txPinOut |-> ##[0:2] rtsPin)
      else $error("rts low in frame");
   a_rts_fall: assert property (drv && $fell(rtsPin) |-> txPinOut)
      else $error("rts fell early");
   a_ir_pulse: assert property (mode[3:0] == LINE_INFRARED && $rose(txPinOut) |-> txPinOut[*5] ##[1:2] !txPinOut)
      else $error("bad pulse");
   a_release_mode: assert property (!txPinOe |-> mode[2] || $past(mode[2]))
      else $error("line released");
   c_echo: cover property (echo && !rxPin);
   c_rts: cover property (drv && $fell(rtsPin));
   c_ir: cover property (mode[3:0] == LINE_INFRARED && $rose(txPinOut));
endmodule
bind usm_core usm_core_chk usm_core_chk_inst (.clock, .srst, .regWrite, .regRead, .rxPin, .txPinOut,
   .txPinOe, .rtsPin, .regAddr, .regWrData, .regRdData);

// ==== dv/usm_card_model.sv ====
// Far side: card or infrared transceiver sending one character.
// Assumes 32 clocks a bit and a pulled-up line.
`timescale 1ns/1ps
module usm_card_model (
   // Clock and line
   input wire logic clock,
   output logic line
);
   initial line = 1'b1;
   // Kind 0 card with even parity, 1 plain, 2 infrared low pulses
   task automatic send(input logic [7:0] d, input logic bad, input logic [1:0] kind);
      logic [13:0] f;
      f = {4'hf, kind != 2'h0 || (^d ^ bad), d, 1'b0};
      for (int i = 0; i < 14; i++) begin
         for (int c = 0; c < 32; c++) begin
            @(posedge clock);
            line <= kind == 2'h2 ? f[i] || c > 5 : f[i];
         end
      end
   endtask
endmodule

// ==== dv/usm_special_line_modes_test.sv ====
// Bench for the special line mode core with a card model.
// Assumes the line is shared only in card modes.
`timescale 1ns/1ps
module usm_special_line_modes_test;
   import usm_pkg::*;
   logic clock = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0, shared = 1'b0, p, txPinOut, txPinOe, rtsPin, line;
   logic [7:0] regAddr = 8'h0, d;
   logic [31:0] regWrData = 32'h0, regRdData, v;
   int failures = 0, total_checks = 0, seed = 97, n, r;
   wire rxPin = shared ? line & (txPinOe ? txPinOut : 1'b1) : line;
   always #25 clock = ~clock;
   usm_core usm_core_inst (.clock, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .rxPin,
      .txPinOut, .txPinOe, .rtsPin);
   usm_card_model usm_card_model_inst (.clock, .line);
   task complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge clock);
      regAddr <= a;
      regWrData <= x;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask
   task snd(input logic b, input logic [1:0] k);
      d = 8'($random(seed));
      usm_card_model_inst.send(d, b, k);
   endtask
   // Counts request-to-send high cycles and rises of the line drive
   task watch;
      n = 0;
      r = 0;
      p = txPinOut;
      repeat (900) begin
         @(posedge clock);
         #1;
         n += rtsPin;
         r += txPinOut & ~p;
         p = txPinOut;
      end
   endtask
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      shared <= 1'b1;
      wr(BAUD_REG_OFS, 32'h2);
      wr(CARD_RATIO_REG_OFS, 32'h1);
      wr(MODE_REG_OFS, 32'h4);
      wr(CONTROL_REG_OFS, 32'h10);
      repeat (3) snd(1'b1, 2'h0);
      rd(ERROR_COUNT_REG_OFS);
      chk("count", 32'h3, v);
      rd(ERROR_COUNT_REG_OFS);
      chk("cleared", 32'h0, v);
      rd(8'h30);
      chk("unmapped", 32'h0, v);
      wr(MODE_REG_OFS, 32'h00100004);
      snd(1'b1, 2'h0);
      rd(CHANNEL_STATUS_REG_OFS);
      chk("inhibit", 32'h2000, v & 32'h2001);
      rd(RECEIVE_HOLDING_REG_OFS);
      chk("holding", 32'(d), v);
      wr(CONTROL_REG_OFS, 32'h4000);
      rd(CHANNEL_STATUS_REG_OFS);
      chk("uninhibit", 32'h0, v & 32'h2000);
      wr(MODE_REG_OFS, 32'h01200004);
      repeat (2) snd(1'b1, 2'h0);
      rd(CHANNEL_STATUS_REG_OFS);
      chk("limit", 32'h400, v & 32'h400);
      rd(RECEIVE_HOLDING_REG_OFS);
      chk("limit holding", 32'(d), v);
      wr(CONTROL_REG_OFS, 32'h2000);
      rd(CHANNEL_STATUS_REG_OFS);
      chk("unlimit", 32'h0, v & 32'h400);
      wr(MODE_REG_OFS, 32'h5);
      snd(1'b1, 2'h0);
      rd(CHANNEL_STATUS_REG_OFS);
      chk("parity", 32'h80, v & 32'h80);
      shared <= 1'b0;
      wr(TIMEGUARD_REG_OFS, 32'h2);
      wr(MODE_REG_OFS, 32'h1);
      wr(CONTROL_REG_OFS, 32'h40);
      wr(TRANSMIT_HOLDING_REG_OFS, 32'($random(seed)) & 32'hff);
      watch;
      chk("rts", 32'h1, 32'(n >= 380 && n <= 392));
      wr(MODE_REG_OFS, 32'h4000);
      snd(1'b0, 2'h1);
      rd(RECEIVE_HOLDING_REG_OFS);
      chk("echo rx", 32'(d), v);
      wr(MODE_REG_OFS, 32'h8);
      d = 8'($random(seed));
      wr(TRANSMIT_HOLDING_REG_OFS, 32'(d));
      watch;
      chk("pulses", 32'(9 - $countones(d)), 32'(r));
      wr(DEMOD_FILTER_REG_OFS, 32'h4);
      snd(1'b0, 2'h2);
      rd(RECEIVE_HOLDING_REG_OFS);
      chk("ir rx", 32'(d), v);
      complete_run;
   end
endmodule
